// ---- core/bcs_boot_clock_sequencer.v ----
// boot clock sequencer top
//
// Overview of operation
// - after reset both pll controllers sit in bypass with plls off
// - async memory interface timing takes slowest setting at reset
// - mode 0100 without fast boot executes straight from cs2 at 0x42000000
// - all other modes start at internal rom 0x00100000
// - decode captured boot mode first, then clocks, then peripherals
// - fast boot puts system pll in pll mode with strapped multiplier
// - secondary pll controller stays in bypass, never touched
// - mode 0100 with fast boot: raise pll, then script load from cs2
// - mode 1001 with fast boot: raise pll, then jump to cs2
// - mode 0111 sets nand interface and reads script from cs2
// - i2c boot runs standard rate without fast boot, fast rate with it
// - fast i2c: prescale 3, half period 39 input clocks
// - standard i2c: prescale 3, half period 150 input clocks
// - uart boot modes load divisor 15
// - spi boot sets sample rate divider to 2, clock source over 3
// - peripheral clock is core clock divided by 6
// - straps captured at reset release into read only register
// - core released once peripheral setup is done, starts at chosen boot address
`timescale 1ns/1ps
`include "bcs_map.vh"
module bcs_boot_clock_sequencer (
    input wire clk_sys_in, // 200 mhz clock
    input wire srst_in, // synchronous reset, active high
    input wire [3:0] boot_mode_strap_in, // boot mode pins
    input wire fast_boot_strap_in, // fast boot pin
    input wire [2:0] boot_multiplier_strap_in, // multiplier pins
    input wire [2:0] memory_pinout_strap_in, // memory pinout pins
    output reg [31:0] latched_strap_out, // read only strap register image
    output reg core_run_out, // core released from reset
    output reg [31:0] core_start_address_out, // first fetch address
    output reg system_pll_enable_out, // system pll in pll mode
    output reg [4:0] system_pll_mult_out, // system pll multiplier
    output reg secondary_pll_enable_out, // secondary pll in pll mode
    output reg [1:0] emif_mode_out, // memory interface mode
    output reg [2:0] emif_pinout_out, // default memory pinout
    output reg script_format_out, // code read as image script
    output reg [7:0] i2c_prescale_out, // i2c prescale field
    output reg [7:0] i2c_low_count_out, // i2c low count field
    output reg [7:0] i2c_high_count_out, // i2c high count field
    output reg [15:0] uart_divisor_out, // boot uart divisor
    output reg [7:0] sample_rate_divider_out, // serial port clock divider
    output reg [3:0] peripheral_div_out, // core clock to peripheral ratio
    output reg boot_done_out // configuration finished
);
    // ------------------------------------------------------------
    // strap synchronisers
    // ------------------------------------------------------------
    // the straps are board pins, so each bit passes two flops before any decode
    wire [`BCS_STRAP_WIDTH-1:0] strap_raw;
    wire [`BCS_STRAP_WIDTH-1:0] strap_sync;
    wire [3:0] sync_mode;
    wire sync_fast;
    wire [2:0] sync_mult;
    wire [2:0] sync_pinout;

    assign strap_raw = {memory_pinout_strap_in, boot_multiplier_strap_in, fast_boot_strap_in,
        boot_mode_strap_in};

    genvar gi;
    generate
        for (gi = 0; gi < `BCS_STRAP_WIDTH; gi = gi + 1) begin : g_strap_sync
            reg meta_q;
            reg sync_q;
            always @(posedge clk_sys_in) begin
                meta_q <= strap_raw[gi];
                sync_q <= meta_q;
            end
            assign strap_sync[gi] = sync_q;
        end
    endgenerate

    assign sync_mode = strap_sync[`BCS_STRAP_MODE_MSB:`BCS_STRAP_MODE_LSB];
    assign sync_fast = strap_sync[`BCS_STRAP_FAST_BIT];
    assign sync_mult = strap_sync[`BCS_STRAP_MULT_MSB:`BCS_STRAP_MULT_LSB];
    assign sync_pinout = strap_sync[`BCS_STRAP_PIN_MSB:`BCS_STRAP_PIN_LSB];

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    localparam ST_CAPTURE = 5'h01;
    localparam ST_DECODE = 5'h02;
    localparam ST_CLOCK = 5'h04;
    localparam ST_PERIPH = 5'h08;
    localparam ST_DONE = 5'h10;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [3:0] mode_q;
    reg [3:0] mode_d;
    reg fast_q;
    reg fast_d;
    reg [2:0] mult_strap_q;
    reg [2:0] mult_strap_d;
    reg direct_q;
    reg direct_d;
    wire [4:0] lut_mult;

    // next values of the output flops
    reg [31:0] latched_strap_d;
    reg [2:0] emif_pinout_d;
    reg system_pll_enable_d;
    reg [4:0] system_pll_mult_d;
    reg [1:0] emif_mode_d;
    reg script_format_d;
    reg [7:0] i2c_prescale_d;
    reg [7:0] i2c_low_count_d;
    reg [7:0] i2c_high_count_d;
    reg [15:0] uart_divisor_d;
    reg [7:0] sample_rate_divider_d;
    reg [31:0] core_start_address_d;
    reg core_run_d;
    reg boot_done_d;

    bcs_mult_lut u_mult (
        .strap_in(mult_strap_q),
        .mult_out(lut_mult)
    );

    always @* begin
        state_d = state_q;
        mode_d = mode_q;
        fast_d = fast_q;
        mult_strap_d = mult_strap_q;
        direct_d = direct_q;
        case (state_q)
            ST_CAPTURE: begin
                // sampled once per reset, so later strap moves are ignored
                mode_d = sync_mode;
                fast_d = sync_fast;
                mult_strap_d = sync_mult;
                state_d = ST_DECODE;
            end
            ST_DECODE: begin
                // mode decode precedes any clock change
                direct_d = (mode_q == `BCS_MODE_EXT_ROM) && !fast_q;
                state_d = ST_CLOCK;
            end
            ST_CLOCK: begin
                state_d = ST_PERIPH;
            end
            ST_PERIPH: begin
                state_d = ST_DONE;
            end
            ST_DONE: begin
                // one sequence per reset, the sequencer parks here
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_CAPTURE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // strap image
    // ------------------------------------------------------------
    always @* begin
        latched_strap_d = latched_strap_out;
        emif_pinout_d = emif_pinout_out;
        if (state_q == ST_CAPTURE) begin
            latched_strap_d = `BCS_IMG_BASE;
            latched_strap_d[`BCS_IMG_FAST_BIT] = sync_fast;
            latched_strap_d[`BCS_IMG_MULT_MSB:`BCS_IMG_MULT_LSB] = sync_mult;
            latched_strap_d[`BCS_IMG_PIN_MSB:`BCS_IMG_PIN_LSB] = sync_pinout;
            latched_strap_d[`BCS_IMG_MODE_MSB:`BCS_IMG_MODE_LSB] = sync_mode;
            emif_pinout_d = sync_pinout;
        end
    end

    // ------------------------------------------------------------
    // clock setup
    // ------------------------------------------------------------
    always @* begin
        system_pll_enable_d = system_pll_enable_out;
        system_pll_mult_d = system_pll_mult_out;
        // direct execution never reaches the rom, so its pll stays in bypass
        if (state_q == ST_CLOCK && fast_q && !direct_q) begin
            system_pll_enable_d = 1'b1;
            system_pll_mult_d = lut_mult;
        end
    end

    // ------------------------------------------------------------
    // peripheral setup
    // ------------------------------------------------------------
    always @* begin
        emif_mode_d = emif_mode_out;
        script_format_d = script_format_out;
        i2c_prescale_d = i2c_prescale_out;
        i2c_low_count_d = i2c_low_count_out;
        i2c_high_count_d = i2c_high_count_out;
        uart_divisor_d = uart_divisor_out;
        sample_rate_divider_d = sample_rate_divider_out;
        if (state_q == ST_PERIPH) begin
            case (mode_q)
                `BCS_MODE_EXT_ROM: begin
                    emif_mode_d = `BCS_EMIF_ASYNC;
                    script_format_d = fast_q;
                end
                `BCS_MODE_EXT_NOAIS: begin
                    emif_mode_d = `BCS_EMIF_ASYNC;
                end
                `BCS_MODE_NAND: begin
                    emif_mode_d = `BCS_EMIF_NAND;
                    script_format_d = 1'b1;
                end
                `BCS_MODE_I2C: begin
                    i2c_prescale_d = `BCS_I2C_PRESCALE;
                    // count plus five prescaled clocks gives each half period
                    if (fast_q) begin
                        i2c_low_count_d = `BCS_I2C_FAST_COUNT;
                        i2c_high_count_d = `BCS_I2C_FAST_COUNT;
                    end else begin
                        i2c_low_count_d = `BCS_I2C_STD_COUNT;
                        i2c_high_count_d = `BCS_I2C_STD_COUNT;
                    end
                end
                `BCS_MODE_UART_NOFC, `BCS_MODE_UART_FC: begin
                    uart_divisor_d = `BCS_UART_DIVISOR;
                end
                `BCS_MODE_SPI16, `BCS_MODE_SPI24: begin
                    sample_rate_divider_d = `BCS_SRG_DIVIDER;
                end
                default: begin
                    // host and reserved modes get no peripheral setup
                    emif_mode_d = `BCS_EMIF_SLOW;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // handover
    // ------------------------------------------------------------
    always @* begin
        core_start_address_d = core_start_address_out;
        core_run_d = core_run_out;
        boot_done_d = boot_done_out;
        // fetch and handover only after all setup is in place
        if (state_q == ST_DONE) begin
            core_start_address_d = direct_q ? `BCS_ADDR_CS2 : `BCS_ADDR_ROM;
            core_run_d = 1'b1;
            boot_done_d = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q <= ST_CAPTURE;
            mode_q <= `BCS_MODE_CLEAR;
            fast_q <= 1'b0;
            mult_strap_q <= `BCS_MULT_STRAP_CLEAR;
            direct_q <= 1'b0;
            latched_strap_out <= `BCS_IMG_CLEAR;
            core_run_out <= 1'b0;
            core_start_address_out <= `BCS_ADDR_ROM;
            system_pll_enable_out <= 1'b0;
            system_pll_mult_out <= `BCS_MULT_ZERO;
            secondary_pll_enable_out <= 1'b0;
            emif_mode_out <= `BCS_EMIF_SLOW;
            emif_pinout_out <= `BCS_PIN_CLEAR;
            script_format_out <= 1'b0;
            i2c_prescale_out <= `BCS_CFG_CLEAR;
            i2c_low_count_out <= `BCS_CFG_CLEAR;
            i2c_high_count_out <= `BCS_CFG_CLEAR;
            uart_divisor_out <= `BCS_UART_CLEAR;
            sample_rate_divider_out <= `BCS_CFG_CLEAR;
            peripheral_div_out <= `BCS_PERIPH_DIV;
            boot_done_out <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            fast_q <= fast_d;
            mult_strap_q <= mult_strap_d;
            direct_q <= direct_d;
            latched_strap_out <= latched_strap_d;
            core_run_out <= core_run_d;
            core_start_address_out <= core_start_address_d;
            system_pll_enable_out <= system_pll_enable_d;
            system_pll_mult_out <= system_pll_mult_d;
            // nothing in the boot sequence reprograms the secondary pll
            secondary_pll_enable_out <= 1'b0;
            emif_mode_out <= emif_mode_d;
            emif_pinout_out <= emif_pinout_d;
            script_format_out <= script_format_d;
            i2c_prescale_out <= i2c_prescale_d;
            i2c_low_count_out <= i2c_low_count_d;
            i2c_high_count_out <= i2c_high_count_d;
            uart_divisor_out <= uart_divisor_d;
            sample_rate_divider_out <= sample_rate_divider_d;
            peripheral_div_out <= `BCS_PERIPH_DIV;
            boot_done_out <= boot_done_d;
        end
    end
endmodule

// ---- core/bcs_map.vh ----
// constants for the boot clock sequencer
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

`define BCS_MODE_EXT_ROM 4'h4
`define BCS_MODE_I2C 4'h5
`define BCS_MODE_SPI16 4'h6
`define BCS_MODE_NAND 4'h7
`define BCS_MODE_UART_NOFC 4'h8
`define BCS_MODE_EXT_NOAIS 4'h9
`define BCS_MODE_UART_FC 4'hE
`define BCS_MODE_SPI24 4'hF

`define BCS_ADDR_CS2 32'h42000000
`define BCS_ADDR_ROM 32'h00100000

`define BCS_I2C_PRESCALE 8'h02
`define BCS_I2C_FAST_COUNT 8'h08
`define BCS_I2C_STD_COUNT 8'h2D
`define BCS_UART_DIVISOR 16'h000F
`define BCS_SRG_DIVIDER 8'h02
`define BCS_PERIPH_DIV 4'h6

`define BCS_EMIF_SLOW 2'h3
`define BCS_EMIF_ASYNC 2'h1
`define BCS_EMIF_NAND 2'h2

`define BCS_MULT_ZERO 5'h00

`define BCS_STRAP_WIDTH 11
`define BCS_STRAP_MODE_LSB 0
`define BCS_STRAP_MODE_MSB 3
`define BCS_STRAP_FAST_BIT 4
`define BCS_STRAP_MULT_LSB 5
`define BCS_STRAP_MULT_MSB 7
`define BCS_STRAP_PIN_LSB 8
`define BCS_STRAP_PIN_MSB 10

`define BCS_IMG_BASE 32'h00200000
`define BCS_IMG_CLEAR 32'h00000000
`define BCS_IMG_FAST_BIT 19
`define BCS_IMG_MULT_LSB 12
`define BCS_IMG_MULT_MSB 14
`define BCS_IMG_PIN_LSB 8
`define BCS_IMG_PIN_MSB 10
`define BCS_IMG_MODE_LSB 0
`define BCS_IMG_MODE_MSB 3

`define BCS_MODE_CLEAR 4'h0
`define BCS_MULT_STRAP_CLEAR 3'h0
`define BCS_PIN_CLEAR 3'h0
`define BCS_CFG_CLEAR 8'h00
`define BCS_UART_CLEAR 16'h0000

`endif

// ---- core/bcs_mult_lut.v ----
// strap to pll multiplier lookup
`timescale 1ns/1ps
module bcs_mult_lut (
    input wire [2:0] strap_in, // multiplier strap
    output reg [4:0] mult_out // pll multiplier
);
    always @* begin
        case (strap_in)
            3'h0: mult_out = 5'h14;
            3'h1: mult_out = 5'h0F;
            3'h2: mult_out = 5'h10;
            3'h3: mult_out = 5'h12;
            3'h4: mult_out = 5'h16;
            3'h5: mult_out = 5'h19;
            3'h6: mult_out = 5'h1B;
            default: mult_out = 5'h1E;
        endcase
    end
endmodule

// ---- verification/bcs_strap_board.sv ----
// board strap model standing at the far side of the boot sequencer
`timescale 1ns/1ps
module bcs_strap_board (
    input wire logic [3:0] mode_sel_in, // wanted boot mode
    input wire logic fast_sel_in, // wanted fast boot
    input wire logic [2:0] mult_sel_in, // wanted multiplier
    input wire logic nand_pin_in, // pick nand pinout for nand boot
    output wire logic [3:0] mode_strap_out, // boot mode pins
    output wire logic fast_strap_out, // fast boot pin
    output wire logic [2:0] mult_strap_out, // multiplier pins
    output wire logic [2:0] pinout_strap_out // memory pinout pins
);
    // the input clock is not modelled, so i2c boot assumes a 21 to 30 mhz source
    assign mode_strap_out = mode_sel_in;
    assign fast_strap_out = fast_sel_in;
    // any table multiplier is taken as legal for the assumed input clock
    assign mult_strap_out = mult_sel_in;
    assign pinout_strap_out = (mode_sel_in == 4'h7 && nand_pin_in) ? 3'h5 : 3'h2;
endmodule

// ---- verification/bcs_seq_props.sv ----
// assertion checker for the boot clock sequencer
`timescale 1ns/1ps
module bcs_seq_props (
    input wire clk_sys_in, // clock
    input wire srst_in, // reset
    input wire [31:0] latched_strap_out, // strap image
    input wire core_run_out, // core released
    input wire [31:0] core_start_address_out, // start address
    input wire system_pll_enable_out, // pll mode
    input wire secondary_pll_enable_out, // second pll
    input wire [1:0] emif_mode_out, // memory mode
    input wire [7:0] i2c_low_count_out, // i2c low count
    input wire [15:0] uart_divisor_out, // uart divisor
    input wire [7:0] sample_rate_divider_out, // serial divider
    input wire [3:0] peripheral_div_out, // peripheral ratio
    input wire boot_done_out // handover
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    wire [3:0] md = latched_strap_out[3:0];
    wire fb = latched_strap_out[19];
    chk_bypass_reset: assert property ($fell(srst_in) |->
        !system_pll_enable_out && !core_run_out && emif_mode_out == 2'h3) else $error("not in bypass after reset");
    chk_done_time: assert property ($fell(srst_in) |-> !boot_done_out[*5] ##1 boot_done_out)
        else $error("handover at wrong cycle");
    chk_start_addr: assert property (boot_done_out |-> core_start_address_out ==
        ((md == 4'h4 && !fb) ? 32'h42000000 : 32'h00100000)) else $error("wrong start address");
    chk_pll_fast: assert property (boot_done_out |-> system_pll_enable_out == fb) else $error("pll mode wrong");
    chk_second_pll: assert property (!secondary_pll_enable_out) else $error("second pll left bypass");
    chk_i2c_rate: assert property (boot_done_out && md == 4'h5 |-> i2c_low_count_out == (fb ? 8'h08 : 8'h2D))
        else $error("i2c count wrong");
    chk_uart_div: assert property (boot_done_out |-> uart_divisor_out ==
        ((md == 4'h8 || md == 4'hE) ? 16'h000F : 16'h0000)) else $error("uart divisor wrong");
    chk_srg_div: assert property (boot_done_out |-> sample_rate_divider_out ==
        ((md == 4'h6 || md == 4'hF) ? 8'h02 : 8'h00)) else $error("serial divider wrong");
    chk_periph_div: assert property (peripheral_div_out == 4'h6) else $error("peripheral ratio wrong");
    chk_config_first: assert property ($rose(boot_done_out) |-> $stable(uart_divisor_out) &&
        $stable(system_pll_enable_out) && $stable(emif_mode_out)) else $error("config after handover");
    chk_strap_hold: assert property (boot_done_out |=> $stable(latched_strap_out)) else $error("strap moved");
endmodule
bind bcs_boot_clock_sequencer bcs_seq_props u_props (.clk_sys_in, .srst_in, .latched_strap_out, .core_run_out,
    .core_start_address_out, .system_pll_enable_out, .secondary_pll_enable_out, .emif_mode_out, .i2c_low_count_out,
    .uart_divisor_out, .sample_rate_divider_out, .peripheral_div_out, .boot_done_out);

// ---- verification/bcs_boot_clock_sequencer_tb_top.sv ----
// self-checking bench for the boot clock sequencer
`timescale 1ns/1ps
module bcs_boot_clock_sequencer_tb_top;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] mode_q = 4'h0;
    logic fast_q = 1'b0;
    logic [2:0] mult_q = 3'h0;
    logic nand_q = 1'b0;
    wire [3:0] bm, pdiv;
    wire [2:0] ms, ps, pin;
    wire [31:0] strap, addr;
    wire fb, run, pll, pll2, scr, done;
    wire [4:0] mul;
    wire [1:0] emif;
    wire [7:0] psc, lo, hi, srg;
    wire [15:0] udiv;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    logic [4:0] mt [8] = '{5'h14, 5'h0F, 5'h10, 5'h12, 5'h16, 5'h19, 5'h1B, 5'h1E};
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    bcs_strap_board u_board (.mode_sel_in(mode_q), .fast_sel_in(fast_q), .mult_sel_in(mult_q), .nand_pin_in(nand_q),
        .mode_strap_out(bm), .fast_strap_out(fb), .mult_strap_out(ms), .pinout_strap_out(ps));
    bcs_boot_clock_sequencer u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .boot_mode_strap_in(bm),
        .fast_boot_strap_in(fb), .boot_multiplier_strap_in(ms), .memory_pinout_strap_in(ps), .latched_strap_out(strap),
        .core_run_out(run), .core_start_address_out(addr), .system_pll_enable_out(pll), .system_pll_mult_out(mul),
        .secondary_pll_enable_out(pll2), .emif_mode_out(emif), .emif_pinout_out(pin), .script_format_out(scr),
        .i2c_prescale_out(psc), .i2c_low_count_out(lo), .i2c_high_count_out(hi), .uart_divisor_out(udiv),
        .sample_rate_divider_out(srg), .peripheral_div_out(pdiv), .boot_done_out(done));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    // straps settle three cycles inside reset since the pins pass a two-flop sync
    task boot(input logic [3:0] m, input logic f, input logic [2:0] x, input logic a);
        logic [2:0] p;
        p = (m == 4'h7 && a) ? 3'h5 : 3'h2;
        @(negedge clk_sys_in);
        srst_in = 1'b1;
        mode_q = m;
        fast_q = f;
        mult_q = x;
        nand_q = a;
        repeat (3) @(negedge clk_sys_in);
        srst_in = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        chk("strap", {11'h001, 1'b0, f, 4'h0, x, 1'b0, p, 4'h0, m}, strap);
        chk("start", (m == 4'h4 && !f) ? 32'h42000000 : 32'h00100000, addr);
        chk("run_done", 32'h3, {run, done});
        chk("pll", {f, f ? mt[x] : 5'h00, 1'b0}, {pll, mul, pll2});
        chk("emif", (m == 4'h4 || m == 4'h9) ? 2'h1 : (m == 4'h7) ? 2'h2 : 2'h3, emif);
        chk("pinout", p, pin);
        chk("script", (m == 4'h4 && f) || m == 4'h7, scr);
        chk("i2c", (m == 4'h5) ? {8'h02, f ? 16'h0808 : 16'h2D2D} : 24'h0, {psc, lo, hi});
        chk("uart", (m == 4'h8 || m == 4'hE) ? 16'h000F : 16'h0000, udiv);
        chk("srg", {(m == 4'h6 || m == 4'hF) ? 8'h02 : 8'h00, 4'h6}, {srg, pdiv});
    endtask
    task t_direct;
        boot(4'h4, 1'b0, 3'h3, 1'b0);
    endtask
    task t_fast_ext;
        for (int i = 0; i < 8; i++) begin
            boot(4'h4, 1'b1, i[2:0], 1'b0);
            boot(4'h9, 1'b1, i[2:0], 1'b0);
        end
    endtask
    task t_nand;
        boot(4'h7, 1'b0, 3'h0, 1'b1);
        boot(4'h7, 1'b1, 3'h5, 1'b0);
    endtask
    task t_serial;
        boot(4'h5, 1'b0, 3'h0, 1'b0);
        boot(4'h5, 1'b1, 3'h2, 1'b0);
        boot(4'h8, 1'b0, 3'h0, 1'b0);
        boot(4'hE, 1'b1, 3'h1, 1'b0);
        boot(4'h6, 1'b1, 3'h4, 1'b0);
        boot(4'hF, 1'b0, 3'h0, 1'b0);
        boot(4'h2, 1'b0, 3'h0, 1'b0);
        boot(4'h1, 1'b0, 3'h0, 1'b0);
        boot(4'h9, 1'b0, 3'h0, 1'b0);
    endtask
    task t_late_strap;
        boot(4'h5, 1'b1, 3'h4, 1'b0);
        mode_q = 4'h4;
        fast_q = 1'b0;
        mult_q = 3'h7;
        repeat (6) @(negedge clk_sys_in);
        chk("held_strap", 32'h00284205, strap);
        chk("held_start", 32'h00100000, addr);
    endtask
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(negedge clk_sys_in);
        t_direct();
        t_fast_ext();
        t_nand();
        t_serial();
        t_late_strap();
        report_and_stop();
    end
endmodule
